// file: rtl/tbp_params.svh
// Offsets, field positions, reset values and widths of the buffered compare PWM timer.
// Contract
// [RULE_01] Channels zero and one can pair into one buffered compare, output on pin zero only.
// [RULE_02] With pairing set, channel zero compare drives the output until channel one is written.
// [RULE_03] After a channel one write, control passes at next overflow; last written pair wins.
// [RULE_04] When paired, channel zero control governs and reports; channel one control is ignored.
// [RULE_05] While paired, the channel one pin is released from timer control.
// [RULE_06] When paired, writing the active channel's compare takes effect at once.
// [RULE_07] With toggle-on-overflow set, the channel pin toggles when the counter reaches modulo.
// [RULE_08] Period is time between overflows; prescale code 000 counts every bus clock.
// [RULE_09] Pulse width runs overflow to match; level select 0 clears, 1 sets the pin.
// [RULE_10] With 8-bit modulo range, period and width vary in 256 steps.
// [RULE_11] Counter at modulo sets overflow flag and restarts from zero on next timer clock.
// [RULE_12] Upper modulo byte write suppresses overflow flag and interrupt until lower byte written.
// [RULE_13] Reset drives every bit of the counter modulo pair to one.
// [RULE_14] Software should reset the counter before writing new modulo values.
// [RULE_15] A three-bit prescale select picks seven divided bus rates or the external clock pin.
// [RULE_16] Counter equal to a channel compare sets, clears or toggles its pin; may interrupt.
// [RULE_17] After reset pairing is clear, so both channels run independently.
`ifndef TBP_PARAMS_SVH
`define TBP_PARAMS_SVH

// ==========================================================================
// Widths.
`define TBP_AW             8
`define TBP_DW             8
`define TBP_CW             16
`define TBP_PSW            3
`define TBP_DIVW           6
`define TBP_NCH            2
`define TBP_NEV            3

// ==========================================================================
// Register offsets.
`define TBP_OFS_SC         8'h00
`define TBP_OFS_CNT_HI     8'h01
`define TBP_OFS_CNT_LO     8'h02
`define TBP_OFS_MOD_HI     8'h03
`define TBP_OFS_MOD_LO     8'h04
`define TBP_OFS_CH0_CTRL   8'h05
`define TBP_OFS_CH0_HI     8'h06
`define TBP_OFS_CH0_LO     8'h07
`define TBP_OFS_CH1_CTRL   8'h08
`define TBP_OFS_CH1_HI     8'h09
`define TBP_OFS_CH1_LO     8'h0A
`define TBP_OFS_IRQ_STAT   8'h0B
`define TBP_OFS_IRQ_MASK   8'h0C
`define TBP_CH_STRIDE      8'h03

// ==========================================================================
// Field positions.
`define TBP_SC_STOP        5
`define TBP_SC_RST         4
`define TBP_CTRL_ACTIVE    7
`define TBP_CTRL_PAIR      5
`define TBP_CTRL_ELSB      3
`define TBP_CTRL_ELSA      2
`define TBP_CTRL_TOV       1
`define TBP_EV_OVF         0
`define TBP_EV_CH0         1
`define TBP_EV_CH1         2
`define TBP_PS_EXT         3'h7

// ==========================================================================
// Reset values.
`define TBP_MOD_RST        16'hFFFF
`define TBP_CMP_RST        16'hFFFF
`define TBP_PS_RST         3'h0

`endif

// file: rtl/tbp_pkg.sv
// State types of the buffered compare PWM timer.
`include "tbp_params.svh"

package tbp_pkg;

   // ==========================================================================
   // Prescaler state.
   typedef struct packed
   {
      logic [`TBP_DIVW-1:0] div;
      logic                 ext_prev;
      logic                 tick;
   } tbp_pre_state_t;

   // ==========================================================================
   // Output pin state of one channel.
   typedef struct packed
   {
      logic pin;
   } tbp_chan_state_t;

   // ==========================================================================
   // Top level state.
   typedef struct packed
   {
      logic [`TBP_DW-1:0]                 rdata;
      logic                               irq;
      logic                               stop;
      logic [`TBP_PSW-1:0]                ps;
      logic [`TBP_CW-1:0]                 cnt;
      logic [`TBP_CW-1:0]                 modv;
      logic                               mod_inh;
      logic [`TBP_NCH-1:0][`TBP_DW-1:0]   ctrl;
      logic [`TBP_NCH-1:0][`TBP_CW-1:0]   cmp;
      logic                               active;
      logic                               last_wr;
      logic [`TBP_NEV-1:0]                stat;
      logic [`TBP_NEV-1:0]                mask;
      logic [`TBP_NCH-1:0]                oe;
      logic [1:0]                         ext_sync;
   } tbp_top_state_t;

endpackage

// file: rtl/tbp_prescaler.sv
// Counter clock prescaler: seven divided bus rates or the external clock pin.
`timescale 1ns/10ps
`include "tbp_params.svh"

module tbp_prescaler
(
   input  wire logic                 core_clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 en_i,
   input  wire logic                 clr_i,
   input  wire logic                 run_i,
   input  wire logic [`TBP_PSW-1:0]  sel_i,
   input  wire logic                 ext_lvl_i,
   output logic                      tick_o
);

   tbp_pkg::tbp_pre_state_t s_q;
   tbp_pkg::tbp_pre_state_t s_d;

   // ==========================================================================
   // Tick generation.
   always_comb
   begin
      s_d          = s_q;
      s_d.ext_prev = ext_lvl_i;
      s_d.div      = clr_i ? '0 : s_q.div + `TBP_DIVW'(1);
      if (!run_i || clr_i)
      begin
         s_d.tick = 1'b0;
      end
      else if (sel_i == `TBP_PS_EXT)
      begin
         s_d.tick = ext_lvl_i && !s_q.ext_prev; // [RULE_15]
      end
      else
      begin
         s_d.tick = &(s_q.div | ~((`TBP_DIVW'(1) << sel_i) - `TBP_DIVW'(1))); // [RULE_08] [RULE_15]
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         s_q <= '0;
      end
      else if (en_i)
      begin
         s_q <= s_d;
      end
   end

   assign tick_o = s_q.tick;

endmodule

// file: rtl/tbp_chan.sv
// Output pin logic of one compare channel.
`timescale 1ns/10ps

module tbp_chan
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        en_i,
   input  wire logic        ovf_i,
   input  wire logic        match_i,
   input  wire logic        tov_i,
   input  wire logic [1:0]  els_i,
   output logic             pin_o
);

   tbp_pkg::tbp_chan_state_t s_q;
   tbp_pkg::tbp_chan_state_t s_d;

   // ==========================================================================
   // Pin update; a compare action overrides a toggle in the same tick.
   always_comb
   begin
      s_d = s_q;
      if (ovf_i && tov_i)
      begin
         s_d.pin = !s_q.pin; // [RULE_07]
      end
      if (match_i)
      begin
         case (els_i)
            2'h1:    s_d.pin = !s_q.pin; // [RULE_16]
            2'h2:    s_d.pin = 1'b0; // [RULE_09] [RULE_16]
            2'h3:    s_d.pin = 1'b1; // [RULE_09] [RULE_16]
            default: s_d.pin = s_d.pin;
         endcase
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         s_q <= '0;
      end
      else if (en_i)
      begin
         s_q <= s_d;
      end
   end

   assign pin_o = s_q.pin;

endmodule

// file: rtl/tbp_top.sv
// Buffered output compare and PWM timer with counter modulo, register port and interrupt.
`timescale 1ns/10ps
`include "tbp_params.svh"

module tbp_top
(
   input  wire logic                core_clk_i,
   input  wire logic                rst_i,
   input  wire logic                en_i,
   input  wire logic [`TBP_AW-1:0]  addr_i,
   input  wire logic [`TBP_DW-1:0]  wdata_i,
   input  wire logic                wr_i,
   input  wire logic                rd_i,
   output logic      [`TBP_DW-1:0]  rdata_o,
   input  wire logic                external_timer_clock_pin_i,
   output logic                     chan_zero_pin_o,
   output logic                     chan_zero_pin_oe_o,
   output logic                     chan_one_pin_o,
   output logic                     chan_one_pin_oe_o,
   output logic                     irq_o
);

   // ==========================================================================
   // Decoding helpers.
   function automatic logic hit(input logic [`TBP_AW-1:0] a, input logic [`TBP_AW-1:0] ofs);
      hit = (a == ofs);
   endfunction

   function automatic logic [`TBP_CW-1:0] put_byte(input logic [`TBP_CW-1:0] v,
                                                   input logic               hi,
                                                   input logic [`TBP_DW-1:0] b);
      put_byte = hi ? {b, v[`TBP_DW-1:0]} : {v[`TBP_CW-1:`TBP_DW], b};
   endfunction

   // ==========================================================================
   // State and combinational signals.
   tbp_pkg::tbp_top_state_t s_q;
   tbp_pkg::tbp_top_state_t s_d;

   logic                             tick;
   logic                             pair;
   logic                             cnt_clr;
   logic                             ovf_ev;
   logic                             ovf_flag_ev;
   logic [`TBP_NCH-1:0]              match_ev;
   logic [`TBP_NCH-1:0][`TBP_CW-1:0] cmp_eff;
   logic [`TBP_NCH-1:0]              chan_ovf;
   logic [`TBP_NCH-1:0]              chan_match;
   logic [`TBP_NCH-1:0]              chan_tov;
   logic [`TBP_NCH-1:0][1:0]         chan_els;
   logic [`TBP_NCH-1:0]              chan_pin;
   logic [`TBP_NCH-1:0]              cmp_wr;
   logic [`TBP_NEV-1:0]              stat_set;
   logic [`TBP_NEV-1:0]              stat_clr;
   logic [`TBP_DW-1:0]               rd_mux;

   // ==========================================================================
   // Prescaler.
   tbp_prescaler u_pre
   (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .en_i       (en_i),
      .clr_i      (cnt_clr),
      .run_i      (!s_q.stop),
      .sel_i      (s_q.ps),
      .ext_lvl_i  (s_q.ext_sync[1]),
      .tick_o     (tick)
   );

   // ==========================================================================
   // Event detection.
   always_comb
   begin
      pair       = s_q.ctrl[0][`TBP_CTRL_PAIR]; // [RULE_01]
      cnt_clr    = wr_i && hit(addr_i, `TBP_OFS_SC) && wdata_i[`TBP_SC_RST];
      // The full 16-bit compare allows 256-step period and width in an 8-bit range.
      ovf_ev     = tick && (s_q.cnt == s_q.modv); // [RULE_10] [RULE_11]
      ovf_flag_ev = ovf_ev && !s_q.mod_inh; // [RULE_12]
      cmp_eff[0] = (pair && s_q.active) ? s_q.cmp[1] : s_q.cmp[0]; // [RULE_02] [RULE_03]
      cmp_eff[1] = s_q.cmp[1];
   end

   // ==========================================================================
   // Per channel control and compare.
   genvar gi;
   generate
      for (gi = 0; gi < `TBP_NCH; gi = gi + 1)
      begin : g_ch
         always_comb
         begin
            match_ev[gi] = tick && (s_q.cnt == cmp_eff[gi]); // [RULE_16]
            cmp_wr[gi]   = wr_i && (hit(addr_i, `TBP_OFS_CH0_HI + `TBP_AW'(gi) * `TBP_CH_STRIDE) ||
                                    hit(addr_i, `TBP_OFS_CH0_LO + `TBP_AW'(gi) * `TBP_CH_STRIDE));
            if (gi != 0 && pair)
            begin
               chan_ovf[gi]   = 1'b0; // [RULE_04]
               chan_match[gi] = 1'b0; // [RULE_04]
            end
            else
            begin
               chan_ovf[gi]   = ovf_ev;
               chan_match[gi] = match_ev[gi];
            end
            chan_tov[gi] = s_q.ctrl[gi][`TBP_CTRL_TOV];
            chan_els[gi] = {s_q.ctrl[gi][`TBP_CTRL_ELSB], s_q.ctrl[gi][`TBP_CTRL_ELSA]};
         end

         tbp_chan u_chan
         (
            .core_clk_i (core_clk_i),
            .rst_i      (rst_i),
            .en_i       (en_i),
            .ovf_i      (chan_ovf[gi]),
            .match_i    (chan_match[gi]),
            .tov_i      (chan_tov[gi]),
            .els_i      (chan_els[gi]),
            .pin_o      (chan_pin[gi])
         );
      end
   endgenerate

   // ==========================================================================
   // Interrupt status events.
   always_comb
   begin
      stat_set                = '0;
      stat_set[`TBP_EV_OVF]   = ovf_flag_ev; // [RULE_11] [RULE_12]
      stat_set[`TBP_EV_CH0]   = match_ev[0]; // [RULE_16]
      stat_set[`TBP_EV_CH1]   = match_ev[1] && !pair; // [RULE_04]
      stat_clr                = '0;
      if (wr_i && hit(addr_i, `TBP_OFS_IRQ_STAT))
      begin
         stat_clr = wdata_i[`TBP_NEV-1:0];
      end
   end

   // ==========================================================================
   // Read multiplexer.
   always_comb
   begin
      rd_mux = '0;
      case (addr_i)
         `TBP_OFS_SC:
         begin
            rd_mux[`TBP_SC_STOP]  = s_q.stop;
            rd_mux[`TBP_PSW-1:0]  = s_q.ps;
         end
         `TBP_OFS_CNT_HI:   rd_mux = s_q.cnt[`TBP_CW-1:`TBP_DW];
         `TBP_OFS_CNT_LO:   rd_mux = s_q.cnt[`TBP_DW-1:0];
         `TBP_OFS_MOD_HI:   rd_mux = s_q.modv[`TBP_CW-1:`TBP_DW];
         `TBP_OFS_MOD_LO:   rd_mux = s_q.modv[`TBP_DW-1:0];
         `TBP_OFS_CH0_CTRL:
         begin
            rd_mux                   = s_q.ctrl[0];
            rd_mux[`TBP_CTRL_ACTIVE] = pair && s_q.active; // [RULE_04]
         end
         `TBP_OFS_CH0_HI:   rd_mux = s_q.cmp[0][`TBP_CW-1:`TBP_DW];
         `TBP_OFS_CH0_LO:   rd_mux = s_q.cmp[0][`TBP_DW-1:0];
         `TBP_OFS_CH1_CTRL: rd_mux = s_q.ctrl[1];
         `TBP_OFS_CH1_HI:   rd_mux = s_q.cmp[1][`TBP_CW-1:`TBP_DW];
         `TBP_OFS_CH1_LO:   rd_mux = s_q.cmp[1][`TBP_DW-1:0];
         `TBP_OFS_IRQ_STAT: rd_mux[`TBP_NEV-1:0] = s_q.stat;
         `TBP_OFS_IRQ_MASK: rd_mux[`TBP_NEV-1:0] = s_q.mask;
         default:           rd_mux = '0;
      endcase
   end

   // ==========================================================================
   // Next state.
   always_comb
   begin
      s_d          = s_q;
      s_d.ext_sync = {s_q.ext_sync[0], external_timer_clock_pin_i};

      if (rd_i)
      begin
         s_d.rdata = rd_mux;
      end

      if (wr_i && hit(addr_i, `TBP_OFS_SC))
      begin
         s_d.stop = wdata_i[`TBP_SC_STOP];
         s_d.ps   = wdata_i[`TBP_PSW-1:0]; // [RULE_15]
      end

      // Counter: restarts from zero on the tick after reaching modulo.
      if (cnt_clr)
      begin
         s_d.cnt = '0;
      end
      else if (ovf_ev)
      begin
         s_d.cnt = '0; // [RULE_08] [RULE_11]
      end
      else if (tick)
      begin
         s_d.cnt = s_q.cnt + `TBP_CW'(1);
      end

      // Modulo pair; the upper byte arms the overflow inhibit.
      if (wr_i && hit(addr_i, `TBP_OFS_MOD_HI))
      begin
         s_d.modv    = put_byte(s_q.modv, 1'b1, wdata_i);
         s_d.mod_inh = 1'b1; // [RULE_12]
      end
      if (wr_i && hit(addr_i, `TBP_OFS_MOD_LO))
      begin
         s_d.modv    = put_byte(s_q.modv, 1'b0, wdata_i);
         s_d.mod_inh = 1'b0; // [RULE_12]
      end

      if (wr_i && hit(addr_i, `TBP_OFS_CH0_CTRL))
      begin
         s_d.ctrl[0] = wdata_i & 8'h2E;
      end
      if (wr_i && hit(addr_i, `TBP_OFS_CH1_CTRL))
      begin
         s_d.ctrl[1] = wdata_i & 8'h0E;
      end

      // Compare writes land at once, also on the active channel.
      if (wr_i && hit(addr_i, `TBP_OFS_CH0_HI))
      begin
         s_d.cmp[0] = put_byte(s_q.cmp[0], 1'b1, wdata_i); // [RULE_06]
      end
      if (wr_i && hit(addr_i, `TBP_OFS_CH0_LO))
      begin
         s_d.cmp[0] = put_byte(s_q.cmp[0], 1'b0, wdata_i); // [RULE_06]
      end
      if (wr_i && hit(addr_i, `TBP_OFS_CH1_HI))
      begin
         s_d.cmp[1] = put_byte(s_q.cmp[1], 1'b1, wdata_i); // [RULE_06]
      end
      if (wr_i && hit(addr_i, `TBP_OFS_CH1_LO))
      begin
         s_d.cmp[1] = put_byte(s_q.cmp[1], 1'b0, wdata_i); // [RULE_06]
      end

      // Buffered channel selection.
      if (!pair)
      begin
         s_d.active  = 1'b0; // [RULE_02]
         s_d.last_wr = 1'b0;
      end
      else
      begin
         if (cmp_wr[1])
         begin
            s_d.last_wr = 1'b1; // [RULE_03]
         end
         else if (cmp_wr[0])
         begin
            s_d.last_wr = 1'b0; // [RULE_03]
         end
         if (ovf_ev)
         begin
            s_d.active = s_q.last_wr; // [RULE_03]
         end
      end

      if (wr_i && hit(addr_i, `TBP_OFS_IRQ_MASK))
      begin
         s_d.mask = wdata_i[`TBP_NEV-1:0];
      end
      s_d.stat = (s_q.stat & ~stat_clr) | stat_set;
      s_d.irq  = |(s_d.stat & s_d.mask);

      s_d.oe[0] = (chan_els[0] != 2'h0) || chan_tov[0]; // [RULE_01]
      s_d.oe[1] = ((chan_els[1] != 2'h0) || chan_tov[1]) && !pair; // [RULE_05]
   end

   // ==========================================================================
   // State register.
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         s_q        <= '0; // [RULE_17]
         s_q.ps     <= `TBP_PS_RST;
         s_q.modv   <= `TBP_MOD_RST; // [RULE_13]
         s_q.cmp[0] <= `TBP_CMP_RST;
         s_q.cmp[1] <= `TBP_CMP_RST;
      end
      else if (en_i)
      begin
         s_q <= s_d;
      end
   end

   // ==========================================================================
   // Outputs.
   assign rdata_o            = s_q.rdata;
   assign irq_o              = s_q.irq;
   assign chan_zero_pin_o    = chan_pin[0]; // [RULE_01]
   assign chan_zero_pin_oe_o = s_q.oe[0];
   assign chan_one_pin_o     = chan_pin[1];
   assign chan_one_pin_oe_o  = s_q.oe[1];

endmodule

// file: verification/tbp_top_chk.sv
// Concurrent checks on the ports of the buffered compare PWM timer.
`timescale 1ns/10ps
`include "tbp_params.svh"

module tbp_top_chk
(
   input  wire logic                core_clk_i,
   input  wire logic                rst_i,
   input  wire logic                en_i,
   input  wire logic [`TBP_AW-1:0]  addr_i,
   input  wire logic [`TBP_DW-1:0]  wdata_i,
   input  wire logic                wr_i,
   input  wire logic                rd_i,
   input  wire logic [`TBP_DW-1:0]  rdata_o,
   input  wire logic                chan_one_pin_o,
   input  wire logic                chan_one_pin_oe_o,
   input  wire logic                irq_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   // ==========================================================================
   // Shadow copies of the registers that the checks compare against.
   logic [7:0]  mod_hi_q;
   logic [7:0]  mod_lo_q;
   logic [7:0]  cmp_lo_q;
   logic        pair_q;
   logic [1:0]  age_q;
   logic        w;
   logic        r;

   assign w = wr_i && en_i;
   assign r = rd_i && en_i;

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         mod_hi_q <= 8'hFF;
         mod_lo_q <= 8'hFF;
         cmp_lo_q <= 8'hFF;
         pair_q   <= 1'b0;
         age_q    <= 2'h0;
      end
      else
      begin
         if (w && addr_i == `TBP_OFS_MOD_HI) mod_hi_q <= wdata_i;
         if (w && addr_i == `TBP_OFS_MOD_LO) mod_lo_q <= wdata_i;
         if (w && addr_i == `TBP_OFS_CH0_LO) cmp_lo_q <= wdata_i;
         if (w && addr_i == `TBP_OFS_CH0_CTRL) pair_q <= wdata_i[`TBP_CTRL_PAIR];
         age_q <= !pair_q ? 2'h0 : ((age_q == 2'h3) ? age_q : age_q + 2'h1);
      end
   end

   // ==========================================================================
   // Assertions.
   a_pair_oe_off: assert property (pair_q && age_q == 2'h3 |-> !chan_one_pin_oe_o)
      else $error("channel one pin driven while paired");
   a_pair_pin_hold: assert property (pair_q && age_q == 2'h3 |-> $stable(chan_one_pin_o))
      else $error("channel one pin moved while paired");
   a_mod_hi_read: assert property (r && addr_i == `TBP_OFS_MOD_HI |=> rdata_o == $past(mod_hi_q))
      else $error("modulo upper byte read wrong");
   a_mod_lo_read: assert property (r && addr_i == `TBP_OFS_MOD_LO |=> rdata_o == $past(mod_lo_q))
      else $error("modulo lower byte read wrong");
   a_cmp_lo_read: assert property (r && addr_i == `TBP_OFS_CH0_LO |=> rdata_o == $past(cmp_lo_q))
      else $error("channel zero compare read wrong");
   a_pair_bit_read: assert property (r && addr_i == `TBP_OFS_CH0_CTRL |=> rdata_o[5] == $past(pair_q))
      else $error("pairing bit read wrong");
   a_active_idle: assert property (r && addr_i == `TBP_OFS_CH0_CTRL && !pair_q |=> !rdata_o[7])
      else $error("active channel bit set while unpaired");
   a_mask_quiet: assert property (w && addr_i == `TBP_OFS_IRQ_MASK && wdata_i == 8'h00 |=> ##1 !irq_o)
      else $error("interrupt high with mask cleared");

   cover property (pair_q && age_q == 2'h3);
   cover property (irq_o);
   cover property (r && addr_i == `TBP_OFS_CH0_CTRL && pair_q);
endmodule

bind tbp_top tbp_top_chk u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i), .en_i(en_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .chan_one_pin_o(chan_one_pin_o),
   .chan_one_pin_oe_o(chan_one_pin_oe_o), .irq_o(irq_o));

// file: verification/tbp_pin_load.sv
// Model of the circuit on the channel pins: pull-downs on both, and pulse timing of channel zero.
`timescale 1ns/10ps

module tbp_pin_load
(
   input  wire logic         core_clk_i,
   input  wire logic         pin0_i,
   input  wire logic         oe0_i,
   input  wire logic         pin1_i,
   input  wire logic         oe1_i,
   output logic              line0_o,
   output logic              line1_o,
   output logic [15:0]       hi_len_o,
   output logic [15:0]       per_len_o
);
   // ==========================================================================
   // Released pins fall to the pull-down level.
   logic [15:0]  hi_cnt;
   logic [15:0]  per_cnt;
   logic         prev;

   assign line0_o = oe0_i ? pin0_i : 1'b0;
   assign line1_o = oe1_i ? pin1_i : 1'b0;

   initial
   begin
      {hi_cnt, per_cnt, prev, hi_len_o, per_len_o} = '0;
   end

   // Measures high time and period of the channel zero line in clock cycles.
   always @(posedge core_clk_i)
   begin
      prev <= line0_o;
      per_cnt <= (line0_o && !prev) ? 16'h0001 : per_cnt + 16'h0001;
      if (line0_o) hi_cnt <= prev ? hi_cnt + 16'h0001 : 16'h0001;
      if (line0_o && !prev) per_len_o <= per_cnt;
      if (!line0_o && prev) hi_len_o <= hi_cnt;
   end
endmodule

// file: verification/testbench.sv
// Self-checking testbench of the buffered compare PWM timer.
`timescale 1ns/10ps
`include "tbp_params.svh"

module testbench;
   typedef struct
   {
      logic [7:0]   ctrl;
      logic [2:0]   ps;
      logic [15:0]  modv;
      logic [15:0]  cmp;
      logic [15:0]  hi;
      logic [15:0]  per;
   } tbp_row_t;

   // ==========================================================================
   // Signals, design and far side.
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic en = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic ext = 1'b0;
   logic ext_run = 1'b0;
   logic [2:0] ext_div = 3'h0;
   logic [7:0] rdata, d;
   logic p0, oe0, p1, oe1, irq, line0, line1;
   logic [15:0] hi_len, per_len;
   int n_mismatch = 0;
   int check_count = 0;
   tbp_row_t rows [5] = '{
      '{8'h0A, 3'h0, 16'h0003, 16'h0002, 16'h0003, 16'h0004},
      '{8'h0E, 3'h0, 16'h0003, 16'h0002, 16'h0001, 16'h0004},
      '{8'h0A, 3'h0, 16'h00FF, 16'h0080, 16'h0081, 16'h0100},
      '{8'h0A, 3'h1, 16'h0003, 16'h0002, 16'h0006, 16'h0008},
      '{8'h0A, 3'h6, 16'h0003, 16'h0001, 16'h0080, 16'h0100}};
   logic [15:0] rst_tab [8] = '{16'h0000, 16'h03FF, 16'h04FF, 16'h0500, 16'h06FF, 16'h0AFF, 16'h0B00, 16'h2000};

   always #2.5 clk = ~clk;
   always @(posedge clk) if (ext_run) ext_div <= ext_div + 3'h1;
   always @(posedge clk) if (ext_run) ext <= ext_div[2];

   tbp_top DUT (.core_clk_i(clk), .rst_i(rst), .en_i(en), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .external_timer_clock_pin_i(ext), .chan_zero_pin_o(p0),
      .chan_zero_pin_oe_o(oe0), .chan_one_pin_o(p1), .chan_one_pin_oe_o(oe1), .irq_o(irq));
   tbp_pin_load u_load (.core_clk_i(clk), .pin0_i(p0), .oe0_i(oe0), .pin1_i(p1), .oe1_i(oe1),
      .line0_o(line0), .line1_o(line1), .hi_len_o(hi_len), .per_len_o(per_len));

   // ==========================================================================
   // Bus cycles, comparison and closing.
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask

   task automatic setup(input logic [7:0] c, input logic [2:0] ps, input logic [15:0] m, input logic [15:0] k);
      wr_reg(`TBP_OFS_SC, {5'h06, ps});
      wr_reg(`TBP_OFS_MOD_HI, m[15:8]);
      wr_reg(`TBP_OFS_MOD_LO, m[7:0]);
      wr_reg(`TBP_OFS_CH0_HI, k[15:8]);
      wr_reg(`TBP_OFS_CH0_LO, k[7:0]);
      wr_reg(`TBP_OFS_CH0_CTRL, c);
      wr_reg(`TBP_OFS_SC, {5'h02, ps});
   endtask

   task automatic meas(input logic [15:0] hi, input logic [15:0] per);
      repeat (int'(per) * 3 + 20) @(posedge clk);
      chk(hi_len, hi);
      chk(per_len, per);
   endtask

   task automatic reset_check();
      for (int i = 0; i < 8; i++)
      begin
         rd_reg(rst_tab[i][15:8], d);
         chk({8'h00, d}, {8'h00, rst_tab[i][7:0]});
      end
      chk({13'h0000, oe0, oe1, irq}, 16'h0000);
      $display("reset test done");
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      #100000;
      n_mismatch++;
      final_report();
   end

   // ==========================================================================
   // Test sequence.
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      reset_check();
      foreach (rows[i])
      begin
         setup(rows[i].ctrl, rows[i].ps, rows[i].modv, rows[i].cmp);
         meas(rows[i].hi, rows[i].per);
         $display("pwm row %0d done", i);
      end
      setup(8'h0A, 3'h7, 16'h0003, 16'h0002);
      ext_run <= 1'b1;
      meas(16'h0018, 16'h0020);
      ext_run <= 1'b0;
      $display("external clock test done");
      setup(8'h2A, 3'h0, 16'h0007, 16'h0002);
      wr_reg(`TBP_OFS_IRQ_STAT, 8'h07);
      meas(16'h0003, 16'h0008);
      chk(oe1, 1'b0);
      chk(line1, 1'b0);
      rd_reg(`TBP_OFS_IRQ_STAT, d);
      chk(d, 8'h03);
      wr_reg(`TBP_OFS_CH1_CTRL, 8'h0E);
      wr_reg(`TBP_OFS_CH1_HI, 8'h00);
      wr_reg(`TBP_OFS_CH1_LO, 8'h05);
      meas(16'h0006, 16'h0008);
      chk(oe1, 1'b0);
      rd_reg(`TBP_OFS_CH0_CTRL, d);
      chk(d, 8'hAA);
      wr_reg(`TBP_OFS_CH0_LO, 8'h03);
      meas(16'h0004, 16'h0008);
      rd_reg(`TBP_OFS_CH0_CTRL, d);
      chk(d, 8'h2A);
      wr_reg(`TBP_OFS_CH0_CTRL, 8'h0A);
      repeat (4) @(posedge clk);
      chk(oe1, 1'b1);
      $display("buffered test done");
      wr_reg(`TBP_OFS_IRQ_MASK, 8'h01);
      wr_reg(`TBP_OFS_MOD_HI, 8'h00);
      wr_reg(`TBP_OFS_IRQ_STAT, 8'h07);
      repeat (30) @(posedge clk);
      chk(irq, 1'b0);
      wr_reg(`TBP_OFS_MOD_LO, 8'h07);
      repeat (20) @(posedge clk);
      chk(irq, 1'b1);
      wr_reg(`TBP_OFS_IRQ_MASK, 8'h00);
      repeat (3) @(posedge clk);
      #1;
      chk(irq, 1'b0);
      wr_reg(`TBP_OFS_SC, 8'h20);
      wr_reg(`TBP_OFS_IRQ_STAT, 8'h07);
      rd_reg(`TBP_OFS_IRQ_STAT, d);
      chk(d, 8'h00);
      @(posedge clk);
      en <= 1'b0;
      wr_reg(`TBP_OFS_IRQ_MASK, 8'h05);
      en <= 1'b1;
      rd_reg(`TBP_OFS_IRQ_MASK, d);
      chk(d, 8'h00);
      $display("interrupt test done");
      @(posedge clk);
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      reset_check();
      final_report();
   end
endmodule
